// ### pkg/gpg_pkg.sv
package gpg_pkg;

  // ****************************************
  // Grant type status encodings
  // ****************************************
  localparam logic [2:0] GPG_ST_LP_READ = 3'h0;
  localparam logic [2:0] GPG_ST_HP_READ = 3'h1;
  localparam logic [2:0] GPG_ST_LP_WRITE = 3'h2;
  localparam logic [2:0] GPG_ST_HP_WRITE = 3'h3;
  localparam logic [2:0] GPG_ST_ACCESS = 3'h6;
  localparam logic [2:0] GPG_ST_IDLE = 3'h7;

  // ****************************************
  // Counts and reset values
  // ****************************************
  localparam int GPG_WR_LIMIT_UNLATCHED = 3;
  localparam int GPG_WR_LIMIT_LATCHED = 4;
  localparam int GPG_CNT_W = 3;
  localparam int GPG_LEN_W = 4;
  localparam logic [GPG_CNT_W-1:0] GPG_CNT_RESET = 3'h0;
  localparam logic [GPG_LEN_W-1:0] GPG_LEN_ZERO = 4'h0;
  localparam logic [GPG_LEN_W-1:0] GPG_LEN_ONE = 4'h1;
  localparam logic [GPG_LEN_W-1:0] GPG_TURN_CLKS = 4'h1;

  // ****************************************
  // Data bus phase
  // ****************************************
  typedef enum logic [1:0] {
    GPG_BUS_IDLE,
    GPG_BUS_TURN,
    GPG_BUS_READ
  } gpg_bus_t;

endpackage : gpg_pkg

// ### design/gpg_wr_counter.sv
`timescale 1ns/10ps

module gpg_wr_counter import gpg_pkg::*; #(
  parameter int CNT_W = GPG_CNT_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_inc,
  input wire logic i_dec,
  output logic [CNT_W-1:0] o_count
);

  // ****************************************
  // Outstanding write grant count
  // ****************************************
  wire logic [CNT_W-1:0] next_count;

  // Grant and data on one edge cancel, so the count holds
  assign next_count = (i_inc && !i_dec) ? o_count + CNT_W'(1) :
                      (!i_inc && i_dec && o_count != '0) ? o_count - CNT_W'(1) : o_count;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_count <= CNT_W'(GPG_CNT_RESET);
    end else begin
      o_count <= next_count;
    end
  end

  chk_cnt_hold_both: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_inc && i_dec) |=> (o_count == $past(o_count)))
    else $error("Count moved on grant with data");

  chk_cnt_inc_grant: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_inc && !i_dec) |=> (o_count == $past(o_count) + CNT_W'(1)))
    else $error("Count missed write grant");

endmodule : gpg_wr_counter

// ### design/gpg_grant_pipeliner.sv
`timescale 1ns/10ps

// Contract
// - With unlatched data-ready, at most three write grants outstanding.
// - Decrementing from latched data-ready raises the write grant limit to four.
// - Write grant and sampled write data on one edge leave count unchanged with unlatched data-ready; latched data-ready decrements one clock later.
// - At the write limit, no grant of any type is asserted.
// - Only write-data grants raise the write count; read grants do not.
// - Below the limit, grants may be asserted on every clock back to back.
// - After a read grant, next grant waits for that read's last data phase.
// - Target inserts one idle turnaround clock between write and following read; here only for write data sampled on the read grant edge or one before.
// - No low-priority read grant while read buffer full is asserted.
// - Sampling buffer full drops grant at once; resumes after sampling it clear.
// - Buffer full blocks only low-priority reads; other grants still flow.
// - Each grant drives grant type status identifying the transaction type.
// - No parity or bus error generation, detection or reporting on this port.
// - Count rises on write grant, falls on sampled write data-ready.
module gpg_grant_pipeliner import gpg_pkg::*; #(
  parameter bit LATCHED_IRDY = 1'b0,
  parameter int LEN_W = GPG_LEN_W
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_req_valid,
  input wire logic [2:0] i_req_type,
  input wire logic [LEN_W-1:0] i_req_len,
  input wire logic i_irdy_n,
  input wire logic i_read_buffer_full_n,
  output logic o_req_taken,
  output logic o_gnt_n,
  output logic [2:0] o_grant_type_status,
  output logic o_read_data_phase,
  output logic o_turnaround,
  output logic [GPG_CNT_W-1:0] o_wr_count
);

  // ****************************************
  // Request decode
  // ****************************************
  wire logic req_is_write;
  wire logic req_is_read;
  wire logic req_is_lp_read;
  wire logic [GPG_CNT_W-1:0] wr_limit;
  wire logic wr_full;
  wire logic rd_spacing_ok;
  wire logic rbf_block;
  wire logic grant_now;
  wire logic wr_data_seen;
  wire logic wr_dec;
  wire logic [GPG_CNT_W-1:0] wr_count;

  logic irdy_seen_q;
  logic irdy_prev;
  logic [LEN_W-1:0] rd_left;
  logic [LEN_W-1:0] rd_pending;
  logic [LEN_W-1:0] next_rd_left;
  logic pend_valid;
  logic pend_turn;
  gpg_bus_t bus_state;
  gpg_bus_t next_bus_state;

  // No parity is generated or checked on this port
  assign req_is_write = (i_req_type == GPG_ST_LP_WRITE) || (i_req_type == GPG_ST_HP_WRITE);
  assign req_is_read = (i_req_type == GPG_ST_LP_READ) || (i_req_type == GPG_ST_HP_READ);
  assign req_is_lp_read = (i_req_type == GPG_ST_LP_READ);

  // A latched decrement lags one clock, so the limit goes up by one
  assign wr_limit = LATCHED_IRDY ? GPG_CNT_W'(GPG_WR_LIMIT_LATCHED) :
                                   GPG_CNT_W'(GPG_WR_LIMIT_UNLATCHED);
  assign wr_full = (wr_count >= wr_limit);

  // Next grant is sampled on the last data phase of the running read
  // Looking one clock ahead lets single-phase reads chain on every clock
  assign rd_spacing_ok = (next_bus_state == GPG_BUS_IDLE) ||
                         ((next_bus_state == GPG_BUS_READ) && (next_rd_left <= GPG_LEN_ONE));

  // Buffer full only stalls low priority reads
  assign rbf_block = req_is_lp_read && !i_read_buffer_full_n;

  // Below the limit, only read data spacing and buffer full on low priority reads delay a grant
  assign grant_now = i_req_valid && !wr_full && rd_spacing_ok && !rbf_block;

  // ****************************************
  // Write grant tracking
  // ****************************************
  assign wr_data_seen = !i_irdy_n && !o_read_data_phase;
  assign wr_dec = LATCHED_IRDY ? irdy_seen_q : wr_data_seen;

  gpg_wr_counter #(
    .CNT_W(GPG_CNT_W)
  ) u_wr_counter (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_inc(grant_now && req_is_write),
    .i_dec(wr_dec),
    .o_count(wr_count)
  );

  // ****************************************
  // Grant outputs
  // ****************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_gnt_n <= 1'b1;
      o_grant_type_status <= GPG_ST_IDLE;
      o_req_taken <= 1'b0;
      o_wr_count <= GPG_CNT_RESET;
      irdy_seen_q <= 1'b0;
      irdy_prev <= 1'b0;
    end else begin
      o_gnt_n <= !grant_now;
      o_grant_type_status <= grant_now ? i_req_type : GPG_ST_IDLE;
      o_req_taken <= grant_now;
      o_wr_count <= wr_count;
      irdy_seen_q <= wr_data_seen;
      irdy_prev <= !i_irdy_n;
    end
  end

  // ****************************************
  // Read data phase and turnaround
  // ****************************************
  // Read data starts the clock after the grant; a write just before costs one idle
  always_comb begin
    next_bus_state = bus_state;
    next_rd_left = rd_left;
    unique case (bus_state)
      GPG_BUS_IDLE: begin
        if (pend_valid && pend_turn) begin
          next_bus_state = GPG_BUS_TURN;
        end else if (pend_valid) begin
          next_bus_state = GPG_BUS_READ;
          next_rd_left = rd_pending;
        end
      end
      GPG_BUS_TURN: begin
        next_bus_state = GPG_BUS_READ;
        next_rd_left = rd_pending;
      end
      GPG_BUS_READ: begin
        if (rd_left > GPG_LEN_ONE) begin
          next_rd_left = rd_left - GPG_LEN_ONE;
        end else if (pend_valid && pend_turn) begin
          next_bus_state = GPG_BUS_TURN;
          next_rd_left = GPG_LEN_ZERO;
        end else if (pend_valid) begin
          next_rd_left = rd_pending;
        end else begin
          next_bus_state = GPG_BUS_IDLE;
          next_rd_left = GPG_LEN_ZERO;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      bus_state <= GPG_BUS_IDLE;
      rd_left <= GPG_LEN_ZERO;
      rd_pending <= GPG_LEN_ZERO;
      pend_valid <= 1'b0;
      pend_turn <= 1'b0;
      o_read_data_phase <= 1'b0;
      o_turnaround <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      rd_left <= next_rd_left;
      if (grant_now && req_is_read) begin
        pend_valid <= 1'b1;
        rd_pending <= (i_req_len == GPG_LEN_ZERO) ? GPG_LEN_ONE : i_req_len;
        pend_turn <= irdy_prev || !i_irdy_n;
      end else if (next_bus_state == GPG_BUS_READ && bus_state != GPG_BUS_READ) begin
        pend_valid <= 1'b0;
      end else if (bus_state == GPG_BUS_READ && rd_left <= GPG_LEN_ONE && pend_valid
                   && !pend_turn) begin
        pend_valid <= 1'b0;
      end
      o_read_data_phase <= (next_bus_state == GPG_BUS_READ);
      o_turnaround <= (next_bus_state == GPG_BUS_TURN);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_lp_read_blocked;
    i_req_valid && req_is_lp_read && !i_read_buffer_full_n;
  endsequence

  sequence s_turn_then_read;
    o_turnaround ##1 o_read_data_phase;
  endsequence

  chk_limit_no_grant: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (wr_count >= wr_limit) |=> o_gnt_n)
    else $error("Grant issued at write limit");

  chk_limit_ceiling: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    wr_count <= wr_limit)
    else $error("Write count above limit");

  chk_rbf_stops_lp: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    s_lp_read_blocked |=> o_gnt_n)
    else $error("Low priority read granted while buffer full");

  chk_rbf_passes_write: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && req_is_write && !wr_full && rd_spacing_ok && !i_read_buffer_full_n)
      |=> !o_gnt_n)
    else $error("Write grant blocked by buffer full");

  chk_status_type: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    !o_gnt_n |-> (o_grant_type_status == $past(i_req_type)))
    else $error("Status does not match grant");

  chk_back_to_back: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (i_req_valid && req_is_write && !wr_full && rd_spacing_ok) [*2] |=> !o_gnt_n)
    else $error("Write grant skipped below limit");

  chk_read_spacing: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (!o_gnt_n && o_grant_type_status == GPG_ST_HP_READ && $past(i_req_len) > GPG_LEN_ONE)
      |=> o_gnt_n)
    else $error("Grant during read data phases");

  chk_write_turn: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_n)
    (pend_valid && pend_turn && bus_state == GPG_BUS_IDLE) |=> s_turn_then_read)
    else $error("Missing turnaround before read");

  chk_reset_idle: assert property (
    @(posedge i_core_clk)
    !i_rst_n |=> (o_gnt_n && o_wr_count == GPG_CNT_RESET))
    else $error("Grant or count not cleared by reset");

endmodule : gpg_grant_pipeliner

// ### testbench/gpg_master_model.sv
`timescale 1ns/10ps

// ****************************************
// Graphics master model
// ****************************************
module gpg_master_model import gpg_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_gnt_n,
  input wire logic [2:0] i_status,
  input wire logic i_read_data,
  input wire logic i_run,
  input wire logic i_lack_space,
  output logic o_irdy_n,
  output logic o_read_buffer_full_n
);
  logic [3:0] pend;
  logic run_q;
  logic lack_q;
  logic rd_q;
  logic wr_gnt;
  assign wr_gnt = !i_gnt_n && (i_status == GPG_ST_LP_WRITE || i_status == GPG_ST_HP_WRITE);
  initial begin
    pend = 4'h0;
    run_q = 1'b0;
    lack_q = 1'b0;
    rd_q = 1'b0;
    o_irdy_n = 1'b1;
    o_read_buffer_full_n = 1'b1;
  end
  // Up to 15 queued write grants are kept, even one on the edge buffer full rises
  always @(posedge i_core_clk) begin
    pend <= pend + {3'h0, wr_gnt} - {3'h0, !o_irdy_n};
    run_q <= i_run;
    lack_q <= i_lack_space;
    rd_q <= i_read_data;
  end
  // Controls are registered first so the bench never races this model; no parity lines
  // No write data in a read data clock or in the idle clock right after it
  always @(negedge i_core_clk) begin
    o_irdy_n <= !(run_q && pend != 4'h0 && !rd_q && !i_read_data);
    o_read_buffer_full_n <= !lack_q;
  end
endmodule : gpg_master_model

// ### testbench/gpg_grant_pipeliner_tb.sv
`timescale 1ns/10ps

module gpg_grant_pipeliner_tb import gpg_pkg::*; ();
  logic clk, rst_n, valid, run, lack, taken, gnt_n, rdp, turn, irdy_n, rbf_n;
  logic [2:0] rtype, st, wrc;
  logic gnt_lat_n, rdp_lat, irdy_lat_n, rbf_lat_n;
  logic [2:0] st_lat, wrc_lat;
  logic [3:0] rlen;
  int err_total = 0;
  int n_compared = 0;
  int k;

  always #20 clk = !clk;

  gpg_grant_pipeliner gpg_grant_pipeliner_i (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_req_valid(valid), .i_req_type(rtype), .i_req_len(rlen), .i_irdy_n(irdy_n),
    .i_read_buffer_full_n(rbf_n), .o_req_taken(taken), .o_gnt_n(gnt_n),
    .o_grant_type_status(st), .o_read_data_phase(rdp), .o_turnaround(turn),
    .o_wr_count(wrc));
  gpg_master_model gpg_master_model_i (.i_core_clk(clk), .i_gnt_n(gnt_n), .i_status(st),
    .i_read_data(rdp), .i_run(run), .i_lack_space(lack), .o_irdy_n(irdy_n),
    .o_read_buffer_full_n(rbf_n));

  // Second arbiter with the latched data-ready decrement, fed the same requests
  gpg_grant_pipeliner #(.LATCHED_IRDY(1'b1)) gpg_grant_pipeliner_lat_i (.i_core_clk(clk),
    .i_rst_n(rst_n), .i_req_valid(valid), .i_req_type(rtype), .i_req_len(rlen),
    .i_irdy_n(irdy_lat_n), .i_read_buffer_full_n(rbf_lat_n), .o_req_taken(),
    .o_gnt_n(gnt_lat_n), .o_grant_type_status(st_lat), .o_read_data_phase(rdp_lat),
    .o_turnaround(), .o_wr_count(wrc_lat));
  gpg_master_model gpg_master_model_lat_i (.i_core_clk(clk), .i_gnt_n(gnt_lat_n),
    .i_status(st_lat), .i_read_data(rdp_lat), .i_run(run), .i_lack_space(lack),
    .o_irdy_n(irdy_lat_n), .o_read_buffer_full_n(rbf_lat_n));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Valid stays up on return; k is the cycle of the grant, 0 if none came
  // A grant that must come and does not ends the run at once
  task automatic req(input logic [2:0] t, input logic [3:0] l, input int lim, input bit must,
                     output int k);
    valid = 1'b1;
    rtype = t;
    rlen = l;
    k = 0;
    for (int i = 1; i <= lim && k == 0; i++) begin
      @(negedge clk);
      if (taken === 1'b1) begin
        k = i;
        chk({5'h0, st}, {5'h0, t});
        chk({7'h0, gnt_n}, 8'h00);
      end
    end
    if (must && k == 0) begin
      chk(8'h00, 8'h01);
      end_of_test;
    end
  endtask : req

  task automatic idle(input int n);
    valid = 1'b0;
    repeat (n) @(negedge clk);
  endtask : idle

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_write;
    run = 1'b1;
    for (int n = 0; n < 6; n++) begin
      req(GPG_ST_LP_WRITE, 4'h0, 2, 1'b1, k);
      chk(k[7:0], 8'h01);
    end
    idle(8);
    run = 1'b0;
    for (int n = 0; n < GPG_WR_LIMIT_UNLATCHED; n++) begin
      req(GPG_ST_HP_WRITE, 4'h0, 2, 1'b1, k);
      chk(k[7:0], 8'h01);
    end
    req(GPG_ST_LP_WRITE, 4'h0, 6, 1'b0, k);
    chk(k[7:0], 8'h00);
    chk({5'h0, wrc}, 8'h03);
    chk({5'h0, wrc_lat}, 8'h04);
    run = 1'b1;
    req(GPG_ST_LP_WRITE, 4'h0, 8, 1'b1, k);
    chk({7'h0, k > 0}, 8'h01);
    idle(12);
    chk({5'h0, wrc}, 8'h00);
    chk({5'h0, wrc_lat}, 8'h00);
  endtask : t_write

  // The second read's three phases follow the first read's with no gap
  task automatic t_read;
    logic [7:0] cnt;
    cnt = 8'h00;
    req(GPG_ST_HP_READ, 4'h3, 2, 1'b1, k);
    chk(k[7:0], 8'h01);
    req(GPG_ST_HP_READ, 4'h3, 6, 1'b1, k);
    chk(k[7:0], 8'h03);
    valid = 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      cnt = cnt + {7'h0, rdp === 1'b1};
    end
    chk(cnt, 8'h03);
    chk({5'h0, wrc}, 8'h00);
  endtask : t_read

  task automatic t_full;
    lack = 1'b1;
    idle(3);
    req(GPG_ST_HP_READ, 4'h1, 2, 1'b1, k);
    chk(k[7:0], 8'h01);
    req(GPG_ST_LP_READ, 4'h1, 6, 1'b0, k);
    chk(k[7:0], 8'h00);
    lack = 1'b0;
    req(GPG_ST_LP_READ, 4'h1, 4, 1'b1, k);
    chk({7'h0, k > 0}, 8'h01);
    lack = 1'b1;
    idle(3);
    req(GPG_ST_LP_WRITE, 4'h0, 2, 1'b1, k);
    chk(k[7:0], 8'h01);
    lack = 1'b0;
    idle(8);
  endtask : t_full

  // Read granted just as the write data lands must see an idle clock
  task automatic t_turn;
    logic seen;
    seen = 1'b0;
    req(GPG_ST_HP_WRITE, 4'h0, 2, 1'b1, k);
    idle(1);
    req(GPG_ST_HP_READ, 4'h2, 4, 1'b1, k);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      seen = seen | (turn === 1'b1);
    end
    chk({7'h0, seen}, 8'h01);
    idle(6);
  endtask : t_turn

  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    valid = 1'b0;
    rtype = 3'h0;
    rlen = 4'h0;
    run = 1'b0;
    lack = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h0, gnt_n}, 8'h01);
    chk({5'h0, st}, 8'h07);
    chk({5'h0, wrc}, 8'h00);
    rst_n = 1'b1;
    t_write;
    t_read;
    t_full;
    t_turn;
    end_of_test;
  end
endmodule : gpg_grant_pipeliner_tb
